// ---- hdl/pvs_regs.sv ----
// loop scale, output floor and switching rate registers of the converter
//
// Notes on behaviour
// - the loop scale word holds a five bit exponent reset to 11001b over an eleven bit mantissa from memory.
// - any scale code inside the supported range is stored and read back unchanged.
// - the decoded scale picks a divider of 0.125, 0.25, 0.5 or 1.0 by the band it falls in.
// - an out of range scale write is refused, flags invalid data and raises the alert.
// - the reference conversion uses the applied scale word itself, not the quantised divider.
// - scale and rate writes reach hardware at once when idle; when running, hardware holds until restore or undervoltage reloads it from memory.
// - the floor limit is a sixteen bit unsigned word loaded from memory and updated on the fly.
// - a target change below the floor while running raises the warning and moves the target to the floor.
// - the warning sets the none of the above, output and min max status bits and alerts the host.
// - a ceiling programmed below the running target gives the same warning response.
// - floor writes outside the FLOOR_LO to FLOOR_HI parameter range are refused as invalid data.
// - the rate word is in kHz and its exponent is generated at reset from the stored frequency.
// - requests up to 600 kHz map onto 225, 275, 325, 375, 450 and 550 kHz.
// - requests above that and below 1650 kHz map onto 650, 750, 900, 1100, 1300 and 1500 kHz.
// - the transition rate governs output changes only during conversion, not during turn on or off.
`timescale 1ns/100ps
`default_nettype none
`include "pvs_defines.svh"
module pvs_regs
#(
    parameter logic [15:0] FLOOR_LO = 16'h0000,
    parameter logic [15:0] FLOOR_HI = 16'hffff
)
(
    input  wire logic                    mclk,
    input  wire logic                    sys_rst,
    input  wire logic                    wr_en,
    input  wire logic                    rd_en,
    input  wire logic [7:0]              cmd_addr,
    input  wire logic [15:0]             wr_data,
    output logic      [15:0]             rd_data,
    output logic                         rd_valid,
    input  wire logic [10:0]             nvm_scale_mantissa,
    input  wire logic [15:0]             nvm_floor,
    input  wire logic [10:0]             nvm_rate_khz,
    input  wire logic                    restore_user,
    input  wire logic                    uvlo_cycle,
    input  wire logic                    conv_en,
    input  wire logic                    sequencing,
    input  wire logic [15:0]             target_req,
    input  wire logic                    target_req_valid,
    input  wire logic [15:0]             ceiling_val,
    input  wire logic                    ceiling_wr,
    input  wire logic                    clear_faults,
    output pvs_pkg::pvs_divider_type     divider,
    output logic      [15:0]             vref_scale_word,
    output logic      [10:0]             rate_khz,
    output logic      [15:0]             vout_target,
    output logic                         use_transition_rate,
    output logic                         status_byte_noa,
    output logic                         status_word_vout,
    output logic                         status_vout_minmax,
    output logic                         status_cml_data,
    output logic                         alert
);
    import pvs_pkg::*;

    generate
        if (FLOOR_LO > FLOOR_HI)
        begin : g_bad_range
            $error("floor limit range is empty");
        end
        if (`PVS_EXP_HI - `PVS_EXP_LO != 4 || `PVS_MAN_HI - `PVS_MAN_LO != 10)
        begin : g_bad_fields
            $error("linear word fields do not match the decoder");
        end
        // the decoder biases the exponent by sixteen, which fixes the binary point
        if (`PVS_FRAC_BITS != 16)
        begin : g_bad_frac
            $error("decoded values must carry sixteen fraction bits");
        end
    endgenerate

    pvs_state_type st_q;
    pvs_state_type st_d;
    pvs_state_type reload;
    logic [2:0]    wsel;
    logic [2:0]    rsel;
    logic [15:0]   nvm_rate_word;

    // lin[0]: write data, lin[1]: applied scale, lin[2]: applied rate
    pvs_lin_if lin[3] ();

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_dec
            pvs_lin_decode u_dec
            (
                .lin (lin[gi])
            );
        end
    endgenerate

    assign lin[0].word = wr_data;
    assign lin[1].word = st_q.hw_scale_word;
    assign lin[2].word = st_q.hw_rate_word;

    function automatic logic [2:0] addr_sel(input logic [7:0] a);
        logic [2:0] s;
        s = 3'h0;
        s[0] = (a == `PVS_OFS_LOOP_SCALE);
        s[1] = (a == `PVS_OFS_FLOOR_LIMIT);
        s[2] = (a == `PVS_OFS_RATE_SELECT);
        return s;
    endfunction

    function automatic pvs_divider_type div_map(input logic signed [47:0] v);
        pvs_divider_type d;
        if (v <= `PVS_Q_EIGHTH)
            d = PVS_DIV_EIGHTH;
        else if (v <= `PVS_Q_QUARTER)
            d = PVS_DIV_QUARTER;
        else if (v <= `PVS_Q_HALF)
            d = PVS_DIV_HALF;
        else
            d = PVS_DIV_ONE;
        return d;
    endfunction

    // a zero or negative scale has no divider to pick, so it is refused
    function automatic logic scale_ok(input logic signed [47:0] v);
        return (v > 48'sh0) && (v <= `PVS_Q_ONE);
    endfunction

    // the top band ends short of 1650 kHz, so that value and above are refused
    function automatic logic rate_ok(input logic signed [47:0] v);
        return (v > 48'sh0) && (v[47:`PVS_FRAC_BITS] < `PVS_FB_TOP);
    endfunction

    function automatic logic floor_ok(input logic [15:0] w);
        return (w >= FLOOR_LO) && (w <= FLOOR_HI);
    endfunction

    // unmapped codes read as zero
    function automatic logic [15:0] read_mux(input logic [2:0] s, input pvs_state_type q);
        logic [15:0] r;
        r = 16'h0000;
        if (s[0])
            r = q.scale_word;
        if (s[1])
            r = q.floor_word;
        if (s[2])
            r = q.rate_word;
        return r;
    endfunction

    // fractional kHz truncate, so a gap value lands in the band below
    function automatic logic [10:0] rate_map(input logic signed [47:0] v);
        logic signed [31:0] k;
        logic        [10:0] f;
        k = v[47:`PVS_FRAC_BITS];
        if (k <= `PVS_FB_0)
            f = `PVS_FE_0;
        else if (k <= `PVS_FB_1)
            f = `PVS_FE_1;
        else if (k <= `PVS_FB_2)
            f = `PVS_FE_2;
        else if (k <= `PVS_FB_3)
            f = `PVS_FE_3;
        else if (k <= `PVS_FB_4)
            f = `PVS_FE_4;
        else if (k <= `PVS_FB_5)
            f = `PVS_FE_5;
        else if (k <= `PVS_FB_6)
            f = `PVS_FE_6;
        else if (k <= `PVS_FB_7)
            f = `PVS_FE_7;
        else if (k <= `PVS_FB_8)
            f = `PVS_FE_8;
        else if (k <= `PVS_FB_9)
            f = `PVS_FE_9;
        else if (k <= `PVS_FB_10)
            f = `PVS_FE_10;
        else
            f = `PVS_FE_11;
        return f;
    endfunction

    // above 1023 kHz the mantissa overflows, so halve it with exponent one
    always_comb
    begin
        if (nvm_rate_khz > `PVS_MAN_MAX)
            nvm_rate_word = {5'h01, 1'b0, nvm_rate_khz[10:1]};
        else
            nvm_rate_word = {5'h00, nvm_rate_khz};
    end

    always_comb
    begin
        reload               = st_q;
        reload.scale_word    = {`PVS_SCALE_RST_EXP, nvm_scale_mantissa};
        reload.hw_scale_word = reload.scale_word;
        reload.floor_word    = nvm_floor;
        reload.rate_word     = nvm_rate_word;
        reload.hw_rate_word  = nvm_rate_word;
    end

    always_comb
    begin
        st_d = st_q;
        wsel = addr_sel(cmd_addr);
        rsel = addr_sel(cmd_addr);
        st_d.rd_valid = rd_en;
        if (rd_en)
            st_d.rd_data = read_mux(rsel, st_q);
        if (clear_faults)
        begin
            st_d.warn_minmax  = 1'b0;
            st_d.invalid_data = 1'b0;
        end
        // a reload overrides any scale, floor or rate write in the same cycle, so that write is lost
        if (restore_user || uvlo_cycle)
        begin
            st_d.scale_word    = reload.scale_word;
            st_d.hw_scale_word = reload.hw_scale_word;
            st_d.floor_word    = reload.floor_word;
            st_d.rate_word     = reload.rate_word;
            st_d.hw_rate_word  = reload.hw_rate_word;
        end
        else if (wr_en)
        begin
            if (wsel[0])
            begin
                if (scale_ok(lin[0].value))
                begin
                    st_d.scale_word = wr_data;
                    if (!conv_en)
                        st_d.hw_scale_word = wr_data;
                end
                else
                    st_d.invalid_data = 1'b1;
            end
            if (wsel[1])
            begin
                if (floor_ok(wr_data))
                    st_d.floor_word = wr_data;
                else
                    st_d.invalid_data = 1'b1;
            end
            if (wsel[2])
            begin
                if (rate_ok(lin[0].value))
                begin
                    st_d.rate_word = wr_data;
                    if (!conv_en)
                        st_d.hw_rate_word = wr_data;
                end
                else
                    st_d.invalid_data = 1'b1;
            end
        end
        // a target request outranks a ceiling write arriving with it
        if (target_req_valid)
        begin
            if (conv_en && target_req < st_q.floor_word)
            begin
                st_d.target      = st_q.floor_word;
                st_d.warn_minmax = 1'b1;
            end
            else
                st_d.target = target_req;
        end
        else if (ceiling_wr && conv_en && ceiling_val < st_q.target)
        begin
            st_d.target      = ceiling_val;
            st_d.warn_minmax = 1'b1;
        end
    end

    // synchronous reset, so reloading from memory inputs here is safe
    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            st_q              <= reload;
            st_q.target       <= 16'h0000;
            st_q.warn_minmax  <= 1'b0;
            st_q.invalid_data <= 1'b0;
            st_q.rd_data      <= 16'h0000;
            st_q.rd_valid     <= 1'b0;
        end
        else
            st_q <= st_d;
    end

    // divider and rate decode straight from the applied copies, so they move on the write edge
    assign divider             = div_map(lin[1].value);
    assign vref_scale_word     = st_q.hw_scale_word;
    assign rate_khz            = rate_map(lin[2].value);
    assign vout_target         = st_q.target;
    assign use_transition_rate = conv_en & ~sequencing;
    assign status_byte_noa     = st_q.warn_minmax;
    assign status_word_vout    = st_q.warn_minmax;
    assign status_vout_minmax  = st_q.warn_minmax;
    assign status_cml_data     = st_q.invalid_data;
    assign alert               = st_q.warn_minmax | st_q.invalid_data;
    assign rd_data             = st_q.rd_data;
    assign rd_valid            = st_q.rd_valid;
endmodule
`default_nettype wire

// ---- hdl/pvs_defines.svh ----
// constants for the loop scale, output floor and switching rate registers
`ifndef PVS_DEFINES_SVH
`define PVS_DEFINES_SVH

// command codes of the three word registers
`define PVS_OFS_LOOP_SCALE   8'h29
`define PVS_OFS_FLOOR_LIMIT  8'h2b
`define PVS_OFS_RATE_SELECT  8'h33

// linear word field layout
`define PVS_EXP_HI           15
`define PVS_EXP_LO           11
`define PVS_MAN_HI           10
`define PVS_MAN_LO           0

// exponent loaded into the loop scale word at reset
`define PVS_SCALE_RST_EXP    5'h19

// decoded values carry 16 fraction bits
`define PVS_FRAC_BITS        16
`define PVS_Q_EIGHTH         48'sh0000_0000_2000
`define PVS_Q_QUARTER        48'sh0000_0000_4000
`define PVS_Q_HALF           48'sh0000_0000_8000
`define PVS_Q_ONE            48'sh0000_0001_0000

// upper ends of the frequency bands in kHz, gaps fall to the lower band
`define PVS_FB_0             32'sd250
`define PVS_FB_1             32'sd300
`define PVS_FB_2             32'sd350
`define PVS_FB_3             32'sd410
`define PVS_FB_4             32'sd500
`define PVS_FB_5             32'sd600
`define PVS_FB_6             32'sd700
`define PVS_FB_7             32'sd820
`define PVS_FB_8             32'sd1000
`define PVS_FB_9             32'sd1200
`define PVS_FB_10            32'sd1400
`define PVS_FB_TOP           32'sd1650

// effective switching rates in kHz
`define PVS_FE_0             11'd225
`define PVS_FE_1             11'd275
`define PVS_FE_2             11'd325
`define PVS_FE_3             11'd375
`define PVS_FE_4             11'd450
`define PVS_FE_5             11'd550
`define PVS_FE_6             11'd650
`define PVS_FE_7             11'd750
`define PVS_FE_8             11'd900
`define PVS_FE_9             11'd1100
`define PVS_FE_10            11'd1300
`define PVS_FE_11            11'd1500

// largest mantissa that fits with a zero exponent
`define PVS_MAN_MAX          11'd1023

`endif

// ---- hdl/pvs_pkg.sv ----
// types shared by the loop scale, floor and rate register logic
`default_nettype none
package pvs_pkg;

    typedef enum logic [1:0] {
        PVS_DIV_EIGHTH,
        PVS_DIV_QUARTER,
        PVS_DIV_HALF,
        PVS_DIV_ONE
    } pvs_divider_type;

    typedef struct packed {
        logic [15:0] scale_word;
        logic [15:0] floor_word;
        logic [15:0] rate_word;
        logic [15:0] hw_scale_word;
        logic [15:0] hw_rate_word;
        logic [15:0] target;
        logic        warn_minmax;
        logic        invalid_data;
        logic [15:0] rd_data;
        logic        rd_valid;
    } pvs_state_type;

endpackage
`default_nettype wire

// ---- hdl/pvs_lin_if.sv ----
// carries one linear word and its decoded fixed point value
`timescale 1ns/100ps
`default_nettype none
interface pvs_lin_if;
    logic        [15:0] word;
    logic signed [47:0] value;
    modport src (output word, input value);
    modport dec (input word, output value);
endinterface
`default_nettype wire

// ---- hdl/pvs_lin_decode.sv ----
// decodes a linear word into a signed value with 16 fraction bits
`timescale 1ns/100ps
`default_nettype none
`include "pvs_defines.svh"
module pvs_lin_decode
(
    pvs_lin_if.dec lin
);
    logic        [4:0]  shift;
    logic signed [47:0] mant_ext;

    // exponent spans -16..15, so adding 16 is a flip of its sign bit
    always_comb
    begin
        shift    = {~lin.word[`PVS_EXP_HI], lin.word[`PVS_EXP_HI-1:`PVS_EXP_LO]};
        mant_ext = {{37{lin.word[`PVS_MAN_HI]}}, lin.word[`PVS_MAN_HI:`PVS_MAN_LO]};
        lin.value = mant_ext <<< shift;
    end
endmodule
`default_nettype wire

// ---- tb/pvs_host_model.sv ----
// host model issuing word reads and writes on the register port
`timescale 1ns/100ps
`default_nettype none
module pvs_host_model
(
    input  wire logic        mclk,
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid,
    output logic             wr_en,
    output logic             rd_en,
    output logic      [7:0]  cmd_addr,
    output logic      [15:0] wr_data
);
    initial
    begin
        wr_en = 1'b0;
        rd_en = 1'b0;
        cmd_addr = 8'h00;
        wr_data = 16'h0000;
    end
    // single phase with the rail fed externally, so fast rates are fair
    // released lines show the inverse so stale values never pass
    task automatic write_word(input logic [7:0] a, input logic [15:0] d);
        @(negedge mclk);
        cmd_addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge mclk);
        wr_en = 1'b0;
        cmd_addr = ~a;
        wr_data = ~d;
    endtask
    task automatic read_word(input logic [7:0] a, output logic v, output logic [15:0] d);
        @(negedge mclk);
        cmd_addr = a;
        rd_en = 1'b1;
        @(negedge mclk);
        v = rd_valid;
        d = rd_data;
        rd_en = 1'b0;
        cmd_addr = ~a;
    endtask
endmodule
`default_nettype wire

// ---- tb/pvs_regs_asserts.sv ----
// port checker for the loop scale, floor and rate registers
`timescale 1ns/100ps
`default_nettype none
module pvs_regs_asserts
(
    input wire logic        mclk,
    input wire logic        sys_rst,
    input wire logic        rd_en,
    input wire logic        rd_valid,
    input wire logic        conv_en,
    input wire logic        sequencing,
    input wire logic        restore_user,
    input wire logic        uvlo_cycle,
    input wire logic [15:0] target_req,
    input wire logic        target_req_valid,
    input wire logic        ceiling_wr,
    input wire logic        clear_faults,
    input wire logic [15:0] vref_scale_word,
    input wire logic [10:0] rate_khz,
    input wire logic [15:0] vout_target,
    input wire logic        use_transition_rate,
    input wire logic        status_byte_noa,
    input wire logic        status_word_vout,
    input wire logic        status_vout_minmax,
    input wire logic        status_cml_data,
    input wire logic        alert
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    a_read_answer: assert property (rd_en |=> rd_valid)
        else $error("read not answered next cycle");
    a_hw_hold: assert property (conv_en && !restore_user && !uvlo_cycle |=>
        $stable(vref_scale_word) && $stable(rate_khz)) else $error("hardware moved while converting");
    a_rate_legal: assert property (rate_khz inside {225, 275, 325, 375, 450, 550, 650, 750, 900, 1100, 1300, 1500})
        else $error("rate not a supported setting");
    a_warn_cause: assert property ($rose(status_vout_minmax) |->
        $past(conv_en) && ($past(target_req_valid) || $past(ceiling_wr))) else $error("warning without cause");
    a_warn_same: assert property (status_byte_noa == status_vout_minmax && status_word_vout == status_vout_minmax)
        else $error("warning bits disagree");
    a_alert_or: assert property (alert == (status_vout_minmax || status_cml_data))
        else $error("alert does not follow status");
    a_warn_sticky: assert property (status_vout_minmax && !clear_faults |=> status_vout_minmax)
        else $error("warning dropped early");
    a_cml_sticky: assert property (status_cml_data && !clear_faults |=> status_cml_data)
        else $error("invalid data flag dropped early");
    a_target_pass: assert property (target_req_valid && !conv_en |=> vout_target == $past(target_req))
        else $error("target not taken while idle");
    a_ramp_gate: assert property (use_transition_rate == (conv_en && !sequencing))
        else $error("transition rate gating wrong");
    c_read: cover property (rd_en ##1 rd_valid);
    c_warn: cover property ($rose(status_vout_minmax));
    c_cml: cover property ($rose(status_cml_data));
endmodule
bind pvs_regs pvs_regs_asserts chk_u (.mclk(mclk), .sys_rst(sys_rst), .rd_en(rd_en), .rd_valid(rd_valid),
    .conv_en(conv_en), .sequencing(sequencing), .restore_user(restore_user), .uvlo_cycle(uvlo_cycle),
    .target_req(target_req), .target_req_valid(target_req_valid), .ceiling_wr(ceiling_wr),
    .clear_faults(clear_faults), .vref_scale_word(vref_scale_word), .rate_khz(rate_khz),
    .vout_target(vout_target), .use_transition_rate(use_transition_rate), .status_byte_noa(status_byte_noa),
    .status_word_vout(status_word_vout), .status_vout_minmax(status_vout_minmax),
    .status_cml_data(status_cml_data), .alert(alert));
`default_nettype wire

// ---- tb/test_pvs_regs.sv ----
// self-checking bench for the loop scale, floor and rate registers
`timescale 1ns/100ps
`default_nettype none
module test_pvs_regs;
    import pvs_pkg::*;
    logic            mclk = 1'b0;
    logic            sys_rst = 1'b1;
    logic            conv_en = 1'b0;
    logic            sequencing = 1'b0;
    logic            restore_user = 1'b0;
    logic            uvlo_cycle = 1'b0;
    logic            target_req_valid = 1'b0;
    logic            ceiling_wr = 1'b0;
    logic            clear_faults = 1'b0;
    logic [15:0]     target_req = 16'h0000;
    logic [15:0]     ceiling_val = 16'h0000;
    logic [15:0]     nvm_floor = 16'h0200;
    logic [10:0]     nvm_scale_mantissa = 11'h040;
    logic [10:0]     nvm_rate_khz = 11'h1f4;
    logic            wr_en, rd_en, rd_valid, use_transition_rate, alert;
    logic            status_byte_noa, status_word_vout, status_vout_minmax, status_cml_data;
    logic [7:0]      cmd_addr;
    logic [15:0]     wr_data, rd_data, vref_scale_word, vout_target;
    logic [10:0]     rate_khz;
    pvs_divider_type divider;
    int              bad_count = 0;
    int              compares = 0;
    always #20 mclk = ~mclk;
    pvs_regs #(.FLOOR_LO(16'h0100), .FLOOR_HI(16'h1000)) dut_u (.mclk(mclk), .sys_rst(sys_rst),
        .wr_en(wr_en), .rd_en(rd_en), .cmd_addr(cmd_addr), .wr_data(wr_data), .rd_data(rd_data),
        .rd_valid(rd_valid), .nvm_scale_mantissa(nvm_scale_mantissa), .nvm_floor(nvm_floor),
        .nvm_rate_khz(nvm_rate_khz), .restore_user(restore_user), .uvlo_cycle(uvlo_cycle),
        .conv_en(conv_en), .sequencing(sequencing), .target_req(target_req),
        .target_req_valid(target_req_valid), .ceiling_val(ceiling_val), .ceiling_wr(ceiling_wr),
        .clear_faults(clear_faults), .divider(divider), .vref_scale_word(vref_scale_word),
        .rate_khz(rate_khz), .vout_target(vout_target), .use_transition_rate(use_transition_rate),
        .status_byte_noa(status_byte_noa), .status_word_vout(status_word_vout),
        .status_vout_minmax(status_vout_minmax), .status_cml_data(status_cml_data), .alert(alert));
    pvs_host_model host_u (.mclk(mclk), .rd_data(rd_data), .rd_valid(rd_valid), .wr_en(wr_en),
        .rd_en(rd_en), .cmd_addr(cmd_addr), .wr_data(wr_data));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        logic        v;
        logic [15:0] d;
        host_u.read_word(a, v, d);
        check({15'h0, v}, 16'h0001);
        check(d, exp);
    endtask
    // k: 0 target, 1 ceiling, 2 clear, 3 restore, 4 undervoltage
    task automatic pulse(input int k, input logic [15:0] v);
        @(negedge mclk);
        target_req = v;
        ceiling_val = v;
        {uvlo_cycle, restore_user, clear_faults, ceiling_wr, target_req_valid} = 5'h01 << k;
        @(negedge mclk);
        {uvlo_cycle, restore_user, clear_faults, ceiling_wr, target_req_valid} = 5'h00;
    endtask
    function automatic logic [15:0] stat();
        return {11'h0, status_cml_data, status_byte_noa, status_word_vout, status_vout_minmax, alert};
    endfunction
    // exponent 1 halves the mantissa above the 11-bit signed reach
    function automatic logic [15:0] rate_word(input int k);
        return (k > 1023) ? {5'h01, 11'(k >> 1)} : {5'h00, 11'(k)};
    endfunction
    task automatic t_reset();
        rchk(8'h29, 16'hc840);
        check({14'h0, divider}, 16'h0002);
        rchk(8'h2b, 16'h0200);
        rchk(8'h33, 16'h01f4);
        check({5'h0, rate_khz}, 16'd450);
        host_u.write_word(8'h30, 16'hffff);
        rchk(8'h30, 16'h0000);
        check(stat(), 16'h0000);
        $display("t_reset done");
    endtask
    task automatic t_run();
        conv_en = 1'b1;
        host_u.write_word(8'h29, 16'hc810);
        host_u.write_word(8'h33, rate_word(300));
        rchk(8'h29, 16'hc810);
        check(vref_scale_word, 16'hc840);
        check({5'h0, rate_khz}, 16'd450);
        pulse(3, 16'h0000);
        rchk(8'h29, 16'hc840);
        nvm_scale_mantissa = 11'h010;
        nvm_rate_khz = 11'd1300;
        pulse(4, 16'h0000);
        check(vref_scale_word, 16'hc810);
        check({14'h0, divider}, 16'h0000);
        check({5'h0, rate_khz}, 16'd1300);
        rchk(8'h33, 16'h0a8a);
        conv_en = 1'b0;
        host_u.write_word(8'h33, rate_word(300));
        check({5'h0, rate_khz}, 16'd275);
        $display("t_run done");
    endtask
    task automatic t_scale();
        logic [15:0] sw [8] = '{16'hc810, 16'hc811, 16'hc820, 16'hc821, 16'hc840, 16'hc841, 16'hc880, 16'hc021};
        logic [1:0]  dv [8] = '{2'd0, 2'd1, 2'd1, 2'd2, 2'd2, 2'd3, 2'd3, 2'd1};
        for (int i = 0; i < 8; i++)
        begin
            host_u.write_word(8'h29, sw[i]);
            rchk(8'h29, sw[i]);
            check({14'h0, divider}, {14'h0, dv[i]});
            check(vref_scale_word, sw[i]);
        end
        // just above 1.0, then zero
        host_u.write_word(8'h29, 16'hc881);
        host_u.write_word(8'h29, 16'hc800);
        check(stat(), 16'h0011);
        rchk(8'h29, 16'hc021);
        pulse(2, 16'h0000);
        $display("t_scale done");
    endtask
    task automatic t_rate();
        int         rq [15] = '{249, 250, 251, 300, 301, 410, 411, 600, 650, 819, 999, 1023, 1300, 1648, 1650};
        logic [10:0] re [15] = '{225, 225, 275, 275, 325, 375, 450, 550, 650, 750, 900, 1100, 1300, 1500, 1500};
        for (int i = 0; i < 15; i++)
        begin
            host_u.write_word(8'h33, rate_word(rq[i]));
            check({5'h0, rate_khz}, {5'h0, re[i]});
        end
        check(stat(), 16'h0011);
        rchk(8'h33, rate_word(1648));
        pulse(2, 16'h0000);
        $display("t_rate done");
    endtask
    task automatic t_floor();
        conv_en = 1'b1;
        host_u.write_word(8'h2b, 16'h0300);
        rchk(8'h2b, 16'h0300);
        host_u.write_word(8'h2b, 16'h00ff);
        check(stat(), 16'h0011);
        host_u.write_word(8'h2b, 16'h1001);
        rchk(8'h2b, 16'h0300);
        pulse(2, 16'h0000);
        check(stat(), 16'h0000);
        pulse(0, 16'h0400);
        check(vout_target, 16'h0400);
        pulse(0, 16'h02ff);
        check(vout_target, 16'h0300);
        check(stat(), 16'h000f);
        pulse(2, 16'h0000);
        pulse(0, 16'h0800);
        pulse(1, 16'h0600);
        check(vout_target, 16'h0600);
        check(stat(), 16'h000f);
        pulse(2, 16'h0000);
        pulse(1, 16'h0900);
        check(vout_target, 16'h0600);
        check(stat(), 16'h0000);
        sequencing = 1'b1;
        @(negedge mclk);
        check({15'h0, use_transition_rate}, 16'h0000);
        sequencing = 1'b0;
        @(negedge mclk);
        check({15'h0, use_transition_rate}, 16'h0001);
        conv_en = 1'b0;
        pulse(0, 16'h0100);
        check(vout_target, 16'h0100);
        check(stat(), 16'h0000);
        $display("t_floor done");
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d mismatches=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #400000;
        bad_count++;
        tally_and_finish();
    end
    initial
    begin
        repeat (12) @(negedge mclk);
        sys_rst = 1'b0;
        t_reset();
        t_run();
        t_scale();
        t_rate();
        t_floor();
        tally_and_finish();
    end
endmodule
`default_nettype wire
